// ===== ocd_pkg.sv
// Purpose: Shared constants and types for the octal converter update control
// Assumes: 16-bit serial words, 12-bit codes, 40 MHz system clock
// Notes:   Header field positions, setting and pin reset values and wake timing counts live here
package ocd_pkg;
   localparam int N_CH   = 8;
   localparam int CODE_W = 12;
   localparam int WORD_W = 16;

   // Word layout
   localparam int DC_BIT      = 15;
   localparam int ADDR_HI     = 14;
   localparam int ADDR_LO     = 12;
   localparam int MODE_HI     = 14;
   localparam int MODE_LO     = 13;
   localparam int RST_SEL_BIT = 12;
   localparam int CTRL_W      = 6;

   typedef enum logic [1:0] {
      OCD_CMD_REFGAIN = 2'h0,
      OCD_CMD_LDMODE  = 2'h1,
      OCD_CMD_PDOWN   = 2'h2,
      OCD_CMD_RESET   = 2'h3
   } ocd_cmd_t;

   // Load-update mode codes
   localparam logic [1:0] LDM_LOW      = 2'h0;
   localparam logic [1:0] LDM_LATCH    = 2'h1;
   localparam logic [1:0] LDM_SINGLE   = 2'h2;
   localparam logic [1:0] LDM_RESERVED = 2'h3;

   // Power-on values
   localparam logic [1:0]        LDM_RESET  = LDM_LATCH;
   localparam logic [N_CH-1:0]   PD_RESET   = 8'h00;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

   // Synchroniser lanes
   localparam int PIN_N     = 5;
   localparam int PIN_SCLK  = 0;
   localparam int PIN_DIN   = 1;
   localparam int PIN_SYNC  = 2;
   localparam int PIN_LD    = 3;
   localparam int PIN_SUP3V = 4;
   localparam logic [PIN_N-1:0] PIN_RESET = 5'h0d;

   // Timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int WAKE_5V_NS    = 2500;
   localparam int WAKE_3V_NS    = 5000;
   localparam logic [7:0] WAKE_5V_CYC =
      8'((WAKE_5V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] WAKE_3V_CYC =
      8'((WAKE_3V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [4:0] BITS_PER_WORD = 5'h10;

   typedef logic [N_CH-1:0][CODE_W-1:0] ocd_code_arr_t;
endpackage : ocd_pkg

// ===== ocd_rx_if.sv
// Purpose: Carries received words and pin levels from the link stage
// Assumes: One sys_clk domain on both sides
// Notes:   word_valid is a one-cycle pulse
`timescale 1ns/1ps
interface ocd_rx_if;
   logic        word_valid;
   logic [15:0] word;
   logic        ld_low;
   logic        supply_3v;
   modport src (output word_valid, output word, output ld_low, output supply_3v);
   modport snk (input word_valid, input word, input ld_low, input supply_3v);
endinterface : ocd_rx_if

// ===== ocd_serial_rx.sv
// Purpose: Samples the serial pins and assembles 16-bit words
// Assumes: Serial clock well below sys_clk / 6
// Notes:   Pins pass three flops; a level counts once flops two and three agree
`timescale 1ns/1ps
module ocd_serial_rx
   import ocd_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic sclk,
   input  wire logic din,
   input  wire logic sync_n,
   input  wire logic load_update_n,
   input  wire logic supply_3v,
   ocd_rx_if.src     rx
);
   logic [PIN_N-1:0] s1_q, s2_q, s3_q, lvl_q;
   logic             sclk_prev_q;
   logic [4:0]       cnt_q;
   logic [14:0]      sh_q;
   logic             valid_q;
   logic [15:0]      word_q;
   logic             active, sclk_fall;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s1_q  <= PIN_RESET;
         s2_q  <= PIN_RESET;
         s3_q  <= PIN_RESET;
         lvl_q <= PIN_RESET;
      end else begin
         s1_q <= {supply_3v, load_update_n, sync_n, din, sclk};
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < PIN_N; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               lvl_q[i] <= s3_q[i];
            end
         end
      end
   end

   // Clock and data are looked at only inside a frame
   assign active    = !lvl_q[PIN_SYNC];
   assign sclk_fall = sclk_prev_q && !lvl_q[PIN_SCLK];

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         // Idle-high clock, so reset must not look like a falling edge
         sclk_prev_q <= PIN_RESET[PIN_SCLK];
         cnt_q       <= 5'h00;
         sh_q        <= 15'h0000;
         valid_q     <= 1'b0;
         word_q      <= 16'h0000;
      end else begin
         sclk_prev_q <= lvl_q[PIN_SCLK];
         valid_q     <= 1'b0;
         if (!active) begin
            cnt_q <= 5'h00;
         end else if (sclk_fall && cnt_q < BITS_PER_WORD) begin
            sh_q  <= {sh_q[13:0], lvl_q[PIN_DIN]};
            cnt_q <= cnt_q + 5'h01;
            // Word released only on the 16th falling edge
            if (cnt_q == BITS_PER_WORD - 5'h01) begin
               valid_q <= 1'b1;
               word_q  <= {sh_q, lvl_q[PIN_DIN]};
            end
         end
      end
   end

   assign rx.word_valid = valid_q;
   assign rx.word       = word_q;
   assign rx.ld_low     = !lvl_q[PIN_LD];
   assign rx.supply_3v  = lvl_q[PIN_SUP3V];

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   property p_abort;
      !active |=> !valid_q;
   endproperty
   a_abort: assert property (p_abort) else $error("word released outside a frame");

   property p_sixteenth;
      active && sclk_fall && cnt_q == 5'h0f |=> valid_q && cnt_q == 5'h10;
   endproperty
   a_sixteenth: assert property (p_sixteenth) else $error("16th edge gave no word");

   c_word: cover property (valid_q);
endmodule : ocd_serial_rx

// ===== ocd_update_ctrl.sv
// Purpose: Command decode, double-buffered banks and load-update control
// Assumes: Serial pins arrive asynchronously; load_update_n is a pin
// Notes:   Output enable per channel models the three-state output stage
`timescale 1ns/1ps
module ocd_update_ctrl
   import ocd_pkg::*;
(
   input  wire logic                     sys_clk,
   input  wire logic                     rst_n,
   input  wire logic                     sclk,
   input  wire logic                     din,
   input  wire logic                     sync_n,
   input  wire logic                     load_update_n,
   input  wire logic                     supply_3v,
   output ocd_pkg::ocd_code_arr_t        dac_code,
   output logic [ocd_pkg::N_CH-1:0]      out_en,
   output logic [ocd_pkg::N_CH-1:0]      pd_state,
   output logic [1:0]                    ld_mode,
   output logic [ocd_pkg::CTRL_W-1:0]    ref_ctrl
);
   import ocd_pkg::*;

   ocd_rx_if rx ();

   ocd_serial_rx u_rx (
      .sys_clk       (sys_clk),
      .rst_n         (rst_n),
      .sclk          (sclk),
      .din           (din),
      .sync_n        (sync_n),
      .load_update_n (load_update_n),
      .supply_3v     (supply_3v),
      .rx            (rx.src)
   );

   function automatic logic is_cmd(input logic [15:0] w, input ocd_cmd_t c);
      return w[DC_BIT] && (w[MODE_HI:MODE_LO] == c);
   endfunction : is_cmd

   ocd_code_arr_t     in_q, conv_q;
   logic [N_CH-1:0]   chg_q, pd_q, en_q;
   logic [1:0]        mode_q;
   logic              single_q;
   logic [CTRL_W-1:0] ctrl_in_q, ctrl_act_q;
   logic              ctrl_chg_q;
   logic [7:0]        wake_q [N_CH];

   logic        wv;
   logic [15:0] w;
   logic        data_wr, pd_cmd, ldm_cmd, rg_cmd, any_rst, full_rst, upd;

   assign wv       = rx.word_valid;
   assign w        = rx.word;
   assign data_wr  = wv && !w[DC_BIT];
   assign pd_cmd   = wv && is_cmd(w, OCD_CMD_PDOWN);
   assign ldm_cmd  = wv && is_cmd(w, OCD_CMD_LDMODE);
   assign rg_cmd   = wv && is_cmd(w, OCD_CMD_REFGAIN);
   assign any_rst  = wv && is_cmd(w, OCD_CMD_RESET);
   assign full_rst = any_rst && w[RST_SEL_BIT];
   // Transparent on mode 00 or a low pin; single update adds one pulse
   assign upd      = mode_q == LDM_LOW || rx.ld_low || single_q;

   // Control settings
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mode_q     <= LDM_RESET;
         single_q   <= 1'b0;
         pd_q       <= PD_RESET;
         ctrl_in_q  <= CTRL_RESET;
         ctrl_act_q <= CTRL_RESET;
         ctrl_chg_q <= 1'b0;
      end else if (full_rst) begin
         mode_q     <= LDM_RESET;
         single_q   <= 1'b0;
         pd_q       <= PD_RESET;
         ctrl_in_q  <= CTRL_RESET;
         ctrl_act_q <= CTRL_RESET;
         ctrl_chg_q <= 1'b0;
      end else begin
         single_q <= 1'b0;
         if (ldm_cmd && w[1:0] == LDM_SINGLE) begin
            single_q <= 1'b1;
            mode_q   <= LDM_LATCH;
         end else if (ldm_cmd && w[1:0] != LDM_RESERVED) begin
            mode_q <= w[1:0];
         end
         if (pd_cmd) begin
            pd_q <= w[N_CH-1:0];
         end
         if (rg_cmd) begin
            ctrl_in_q <= w[CTRL_W-1:0];
         end
         // Ref settings take the same double buffering as codes; set wins
         if (upd && ctrl_chg_q) begin
            ctrl_act_q <= ctrl_in_q;
         end
         ctrl_chg_q <= (ctrl_chg_q && !upd) || rg_cmd;
      end
   end

   // Data banks; power-down never touches them
   always_ff @(posedge sys_clk) begin
      if (!rst_n || any_rst) begin
         in_q   <= '0;
         conv_q <= '0;
         chg_q  <= '0;
      end else begin
         for (int i = 0; i < N_CH; i++) begin
            if (upd && chg_q[i]) begin
               conv_q[i] <= in_q[i];
            end
            if (data_wr && w[ADDR_HI:ADDR_LO] == 3'(i)) begin
               in_q[i]  <= w[CODE_W-1:0];
               chg_q[i] <= 1'b1;
            end else if (upd) begin
               chg_q[i] <= 1'b0;
            end
         end
      end
   end

   // Output stage: open while down, valid after the wake time
   generate
      for (genvar g = 0; g < N_CH; g++) begin : g_wake
         always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
               wake_q[g] <= 8'h00;
               en_q[g]   <= 1'b1;
            end else if (pd_q[g]) begin
               wake_q[g] <= 8'h00;
               en_q[g]   <= 1'b0;
            end else if (!en_q[g]) begin
               if (wake_q[g] >= (rx.supply_3v ? WAKE_3V_CYC : WAKE_5V_CYC) - 8'h01) begin
                  en_q[g] <= 1'b1;
               end else begin
                  wake_q[g] <= wake_q[g] + 8'h01;
               end
            end
         end
      end
   endgenerate

   assign dac_code = conv_q;
   assign out_en   = en_q;
   assign pd_state = pd_q;
   assign ld_mode  = mode_q;
   assign ref_ctrl = ctrl_act_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   property p_pd;
      pd_cmd |=> pd_q == $past(w[N_CH-1:0]);
   endproperty
   a_pd: assert property (p_pd) else $error("power-down selection not taken");

   property p_data_rst;
      any_rst |=> conv_q == '0 && in_q == '0 && chg_q == '0;
   endproperty
   a_data_rst: assert property (p_data_rst) else $error("data reset left codes");

   property p_full_rst;
      full_rst |=> mode_q == LDM_LATCH && pd_q == '0 && ctrl_act_q == '0;
   endproperty
   a_full_rst: assert property (p_full_rst) else $error("full reset left settings");

   property p_write;
      data_wr && w[ADDR_HI:ADDR_LO] == 3'h5 |=> in_q[5] == $past(w[CODE_W-1:0]) && chg_q[5];
   endproperty
   a_write: assert property (p_write) else $error("input register not written");

   property p_hold;
      mode_q == LDM_LATCH && !rx.ld_low && !single_q && !any_rst |=> $stable(conv_q);
   endproperty
   a_hold: assert property (p_hold) else $error("converter changed while latched");

   property p_follow;
      (mode_q == LDM_LOW || rx.ld_low) && chg_q[0] && !any_rst |=> conv_q[0] == $past(in_q[0]);
   endproperty
   a_follow: assert property (p_follow) else $error("transparent load missed");

   property p_unchanged;
      upd && !chg_q[2] && !any_rst |=> $stable(conv_q[2]);
   endproperty
   a_unchanged: assert property (p_unchanged) else $error("unchanged channel reloaded");

   property p_single;
      ldm_cmd && w[1:0] == LDM_SINGLE && !full_rst |=> single_q ##1 (!single_q && mode_q == LDM_LATCH);
   endproperty
   a_single: assert property (p_single) else $error("single update not one pulse");

   property p_reserved;
      ldm_cmd && w[1:0] == LDM_RESERVED |=> $stable(mode_q);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved mode accepted");

   property p_wake;
      $fell(pd_q[0]) ##1 (!pd_q[0])[*8] |-> !en_q[0];
   endproperty
   a_wake: assert property (p_wake) else $error("output valid too early");

   property p_off;
      pd_q[1] |=> !en_q[1];
   endproperty
   a_off: assert property (p_off) else $error("powered-down output driven");

   c_pd: cover property (pd_cmd && w[N_CH-1:0] != '0);
   c_single: cover property (single_q && chg_q != '0);
   c_full_rst: cover property (full_rst);
   c_pin_load: cover property ($rose(rx.ld_low) && chg_q != '0);
endmodule : ocd_update_ctrl

// ===== ocd_host_model.sv
// Purpose: Host side of the three-wire link, a 16-bit word serial master
// Assumes: Serial clock period 200 ns, idle high between frames
// Notes:   Link clock only toggles inside frames or when stray() is called
`timescale 1ns/1ps
module ocd_host_model (
   output logic sclk,
   output logic din,
   output logic sync_n
);
   localparam time HALF = 100ns;

   initial begin
      sclk   = 1'b1;
      din    = 1'b1;
      sync_n = 1'b1;
   end

   // Fewer than 16 bits makes an aborted frame
   task automatic frame(input logic [15:0] w, input int nbits);
      int i;
      #7;
      sync_n = 1'b0;
      #HALF;
      for (i = 0; i < nbits; i++) begin
         din = w[15-i];
         #HALF;
         sclk = 1'b0;
         #HALF;
         sclk = 1'b1;
         if (i == 7) begin
            #(4*HALF);
         end
      end
      #HALF;
      sync_n = 1'b1;
      // Released line must not keep showing the last bit
      din = ~din;
   endtask : frame

   // Clock edges with frame sync high, data changing every edge
   task automatic stray(input int n);
      int i;
      for (i = 0; i < n; i++) begin
         din = ~din;
         #HALF;
         sclk = ~sclk;
      end
      sclk = 1'b1;
   endtask : stray
endmodule : ocd_host_model

// ===== ocd_update_ctrl_test.sv
// Purpose: Self-checking bench for the converter update control
// Assumes: Host model drives the link; bench drives the pins and reset
// Notes:   Expected banks are tracked in exp_dac from the command encoding
`timescale 1ns/1ps
module ocd_update_ctrl_test;
   import ocd_pkg::*;
   logic              sys_clk;
   logic              rst_n;
   logic              load_update_n;
   logic              supply_3v;
   wire logic         sclk;
   wire logic         din;
   wire logic         sync_n;
   ocd_code_arr_t     dac_code;
   ocd_code_arr_t     exp_dac;
   logic [N_CH-1:0]   out_en;
   logic [N_CH-1:0]   pd_state;
   logic [1:0]        ld_mode;
   logic [CTRL_W-1:0] ref_ctrl;
   int                err_count;
   int                checks;
   int                cycles;
   int                i;

   ocd_host_model host_u (.sclk(sclk), .din(din), .sync_n(sync_n));

   ocd_update_ctrl dut_u (
      .sys_clk(sys_clk), .rst_n(rst_n), .sclk(sclk), .din(din), .sync_n(sync_n),
      .load_update_n(load_update_n), .supply_3v(supply_3v), .dac_code(dac_code),
      .out_en(out_en), .pd_state(pd_state), .ld_mode(ld_mode), .ref_ctrl(ref_ctrl)
   );

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : complete_run

   // Run is about 5000 cycles; the ceiling leaves ample margin
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 30000) begin
         err_count++;
         complete_run();
      end
   end

   task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   function automatic logic [15:0] dw(input logic [2:0] ch, input logic [11:0] c);
      return {1'b0, ch, c};
   endfunction : dw

   function automatic logic [15:0] cw(input logic [1:0] m, input logic [12:0] p);
      return {1'b1, m, p};
   endfunction : cw

   task automatic send(input logic [15:0] w);
      host_u.frame(w, 16);
      repeat (12) @(negedge sys_clk);
   endtask : send

   task automatic pulse;
      @(posedge sys_clk);
      load_update_n <= 1'b0;
      repeat (6) @(posedge sys_clk);
      load_update_n <= 1'b1;
      repeat (8) @(negedge sys_clk);
   endtask : pulse

   task automatic t_reset_vals;
      chk(dac_code, '0);
      chk(out_en, 8'hff);
      chk(pd_state, 8'h00);
      chk(ld_mode, LDM_LATCH);
      chk(ref_ctrl, CTRL_RESET);
      $display("test reset_vals done");
   endtask : t_reset_vals

   task automatic t_latched;
      send(dw(3'h3, 12'habc));
      chk(dac_code, exp_dac);
      host_u.frame(dw(3'h5, 12'h111), 12);
      host_u.stray(8);
      repeat (12) @(negedge sys_clk);
      pulse();
      exp_dac[3] = 12'habc;
      chk(dac_code, exp_dac);
      $display("test latched done");
   endtask : t_latched

   task automatic t_sync_update;
      for (i = 0; i < 7; i++) begin
         send(dw(3'(i), 12'h100 + 12'(i)));
         exp_dac[i] = 12'h100 + 12'(i);
      end
      chk({dac_code[3], dac_code[0]}, {12'habc, 12'h000});
      @(posedge sys_clk);
      load_update_n <= 1'b0;
      send(dw(3'h7, 12'h7e7));
      exp_dac[7] = 12'h7e7;
      chk(dac_code, exp_dac);
      @(posedge sys_clk);
      load_update_n <= 1'b1;
      send(cw(OCD_CMD_LDMODE, {11'h0, LDM_LOW}));
      chk(ld_mode, LDM_LOW);
      send(dw(3'h2, 12'h222));
      exp_dac[2] = 12'h222;
      chk(dac_code, exp_dac);
      $display("test sync_update done");
   endtask : t_sync_update

   task automatic t_single;
      send(cw(OCD_CMD_LDMODE, {11'h0, LDM_RESERVED}));
      chk(ld_mode, LDM_LOW);
      send(cw(OCD_CMD_LDMODE, {11'h0, LDM_LATCH}));
      send(dw(3'h4, 12'h444));
      chk(dac_code, exp_dac);
      send(cw(OCD_CMD_LDMODE, {11'h0, LDM_SINGLE}));
      exp_dac[4] = 12'h444;
      chk(dac_code, exp_dac);
      chk(ld_mode, LDM_LATCH);
      send(dw(3'h4, 12'h555));
      chk(dac_code, exp_dac);
      $display("test single done");
   endtask : t_single

   task automatic t_ref;
      send(cw(OCD_CMD_REFGAIN, 13'h002a));
      chk(ref_ctrl, 6'h00);
      pulse();
      exp_dac[4] = 12'h555;
      chk(ref_ctrl, 6'h2a);
      chk(dac_code, exp_dac);
      $display("test ref done");
   endtask : t_ref

   task automatic t_pdown;
      int v;
      int n;
      int wake;
      for (v = 0; v < 2; v++) begin
         wake = (v == 1) ? int'(WAKE_3V_CYC) : int'(WAKE_5V_CYC);
         @(posedge sys_clk);
         supply_3v <= v[0];
         send(cw(OCD_CMD_PDOWN, 13'h0081));
         chk(pd_state, 8'h81);
         chk(out_en, 8'h7e);
         @(posedge sys_clk);
         load_update_n <= 1'b0;
         send(dw(3'h0, 12'h0f0 + 12'(v)));
         exp_dac[0] = 12'h0f0 + 12'(v);
         chk(dac_code, exp_dac);
         chk(out_en, 8'h7e);
         @(posedge sys_clk);
         load_update_n <= 1'b1;
         n = 0;
         // Wake time counts from the cleared selection, mid-frame
         fork
            host_u.frame(cw(OCD_CMD_PDOWN, 13'h0000), 16);
            begin
               while (pd_state !== 8'h00 && n < 400) begin
                  @(negedge sys_clk);
                  n++;
               end
               n = 0;
               while (out_en !== 8'hff && n < 400) begin
                  @(negedge sys_clk);
                  n++;
               end
            end
         join
         chk(n >= wake - 1 && n <= wake + 3, 1'b1);
      end
      $display("test pdown done");
   endtask : t_pdown

   task automatic t_reset_cmd;
      send(cw(OCD_CMD_PDOWN, 13'h0002));
      send(cw(OCD_CMD_RESET, 13'h0000));
      exp_dac = '0;
      chk(dac_code, exp_dac);
      chk({pd_state, ref_ctrl}, {8'h02, 6'h2a});
      send(cw(OCD_CMD_LDMODE, {11'h0, LDM_LOW}));
      send(cw(OCD_CMD_RESET, 13'h1000));
      chk({ld_mode, pd_state, ref_ctrl}, {LDM_RESET, PD_RESET, CTRL_RESET});
      chk(dac_code, exp_dac);
      $display("test reset_cmd done");
   endtask : t_reset_cmd

   initial begin
      rst_n         = 1'b0;
      load_update_n = 1'b1;
      supply_3v     = 1'b0;
      err_count     = 0;
      checks        = 0;
      cycles        = 0;
      exp_dac       = '0;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (6) @(negedge sys_clk);
      t_reset_vals();
      t_latched();
      t_sync_update();
      t_single();
      t_ref();
      t_pdown();
      t_reset_cmd();
      complete_run();
   end
endmodule : ocd_update_ctrl_test
